// file: tpe_cmp_if.sv
// interface between top and relay comparator
`timescale 1ns/1ns
`default_nettype none
interface tpe_cmp_if;
    logic [11:0] temp;
    logic [11:0] thresh;
    logic [11:0] hyst;
    logic noninv;
    logic tick;
    logic drive;
    logic change;
    modport top (output temp, thresh, hyst, noninv, tick, input drive, change);
    modport cmp (input temp, thresh, hyst, noninv, tick, output drive, change);
endinterface : tpe_cmp_if
`default_nettype wire

// file: tpe_mcu_model.sv
// microcontroller side: timer capture of pwm highs and a pulled-up relay input
`timescale 1ns/1ns
`default_nettype none
module tpe_mcu_model (
    input wire logic sys_clk,
    input wire logic obj_pwm,
    input wire logic relay_out,
    input wire logic relay_oe,
    output logic relay_level,
    output logic [31:0] obj_hi_cycles
);
    // pull-up: a released open-drain pin reads high, never the last value
    assign relay_level = relay_oe ? relay_out : 1'b1;
    always_ff @(posedge sys_clk) begin
        obj_hi_cycles <= obj_pwm ? obj_hi_cycles + 32'h00000001 : 32'h00000000;
    end
endmodule : tpe_mcu_model
`default_nettype wire

// file: tpe_pkg.sv
// package with constants and types of the thermometer pwm encoder
`default_nettype none
package tpe_pkg;
    localparam int CLK_HZ = 100000000;
    localparam int PWM_TICK_US = 50;
    localparam int PWM_TICK_CYC = (PWM_TICK_US * (CLK_HZ / 1000000));
    localparam int FRAME_LEN = 2048;
    localparam logic [10:0] LEAD_END = 11'h100;
    localparam logic [10:0] DUTY_UNDER = 11'h580;
    localparam logic [10:0] DUTY_OVER = 11'h600;
    localparam logic [10:0] DUTY_FATAL = 11'h680;
    localparam logic [9:0] VAL_MIN = 10'h000;
    localparam logic [9:0] VAL_MAX = 10'h3FF;
    // wishbone map
    localparam logic [7:0] ADR_OBJ_TEMP = 8'h00;
    localparam logic [7:0] ADR_AMB_TEMP = 8'h04;
    localparam logic [7:0] ADR_COND = 8'h08;
    localparam logic [7:0] ADR_CTRL = 8'h0C;
    localparam logic [7:0] ADR_THRESH = 8'h10;
    localparam logic [7:0] ADR_HYST = 8'h14;
    localparam logic [7:0] ADR_STATUS = 8'h18;
    localparam logic [7:0] ADR_IRQ_EN = 8'h1C;
    localparam logic [7:0] ADR_IRQ_CLR = 8'h20;
    // cond bits: 0 obj low, 1 obj high, 2 amb low, 3 amb high, 4 fatal
    localparam int COND_OBJ_LO = 0;
    localparam int COND_OBJ_HI = 1;
    localparam int COND_AMB_LO = 2;
    localparam int COND_AMB_HI = 3;
    localparam int COND_FATAL = 4;
    localparam int CTRL_NONINV = 0;
    localparam int CTRL_ENABLE = 1;
    // relay enabled, inverting polarity
    localparam logic [1:0] CTRL_RST = 2'h2;
    // 12-bit code: 0.1 degC per lsb, offset -40 degC
    localparam logic [11:0] THRESH_RST = 12'h384;
    localparam logic [11:0] HYST_RST = 12'h032;
    localparam logic [31:0] UNMAPPED = 32'h00000000;
    // status bits: 0 frame start, 1 relay change, 2 fault enter
    localparam int EV_FRAME = 0;
    localparam int EV_RELAY = 1;
    localparam int EV_FAULT = 2;
    localparam int NEV = 3;
    typedef enum logic [1:0] {TPE_NORMAL, TPE_UNDER, TPE_OVER, TPE_FATAL} tpe_mode_t;
endpackage : tpe_pkg
`default_nettype wire

// file: tpe_pwm_ch.sv
// one pwm output channel driven by a shared frame counter
`timescale 1ns/1ns
`default_nettype none
module tpe_pwm_ch (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic tick,
    input wire logic [10:0] pos,
    input wire logic [10:0] high_end,
    output logic pwm
);
    // high from frame start until high_end, so lead buffer is always high
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pwm <= 1'b0;
        end else if (ce && tick) begin
            pwm <= (pos < high_end);
        end
    end
endmodule : tpe_pwm_ch
`default_nettype wire

// file: tpe_relay_cmp.sv
// relay comparator with hysteresis and polarity
`timescale 1ns/1ns
`default_nettype none
module tpe_relay_cmp (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic ce,
    tpe_cmp_if.cmp c
);
    logic above;
    logic [12:0] low_lim;
    assign low_lim = {1'b0, c.thresh} - {1'b0, c.hyst};
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            above <= 1'b0;
        end else if (ce && c.tick) begin
            if (c.temp > c.thresh) begin
                above <= 1'b1;
            // a negative release point can never be reached, so the state holds
            end else if (!low_lim[12] && ({1'b0, c.temp} < low_lim)) begin
                above <= 1'b0;
            end
        end
    end
    // inverting: drive off above threshold
    assign c.drive = c.noninv ? above : ~above;
    logic above_d;
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            above_d <= 1'b0;
        end else if (ce) begin
            above_d <= above;
        end
    end
    assign c.change = ce && (above != above_d);
endmodule : tpe_relay_cmp
`default_nettype wire

// file: tpe_tb.sv
// self-checking testbench of the thermometer pwm encoder
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic sys_clk;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic [11:0] fine = 12'h300;
    logic [4:0] cond = 5'h00;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, obj_out, amb_out, rel_out, rel_oe, f_under, f_over, f_fatal, irq, rel_level;
    logic [31:0] hi_cyc;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    tpe_top uut (.sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .obj_temp_in(10'h155),
        .amb_temp_in(10'h0AA), .obj_temp_fine(fine), .cond_in(cond), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .object_temp_out(obj_out), .ambient_temp_out(amb_out), .relay_drive_out(rel_out),
        .relay_drive_oe(rel_oe), .ambient_underflow_flag(f_under),
        .ambient_overflow_flag(f_over), .memory_fatal_error(f_fatal), .irq(irq));
    tpe_mcu_model mcu (.sys_clk(sys_clk), .obj_pwm(obj_out), .relay_out(rel_out),
        .relay_oe(rel_oe), .relay_level(rel_level), .obj_hi_cycles(hi_cyc));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up
    // a hang in any wait ends here
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            failures++;
            wrap_up;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic xfer(input logic [7:0] a, input logic we, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= wd;
        do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge sys_clk);
    endtask : xfer
    // one pwm tick is 5000 cycles; a little margin for the registered compare
    task automatic tick_wait;
        repeat (5010) @(posedge sys_clk);
    endtask : tick_wait
    task automatic t_regs;
        logic [31:0] d;
        xfer(tpe_pkg::ADR_THRESH, 1'b0, 32'h00000000, d);
        check(d, {20'h00000, tpe_pkg::THRESH_RST});
        xfer(tpe_pkg::ADR_HYST, 1'b0, 32'h00000000, d);
        check(d, {20'h00000, tpe_pkg::HYST_RST});
        // below threshold after reset, inverting: comparator drives the relay
        xfer(tpe_pkg::ADR_CTRL, 1'b0, 32'h00000000, d);
        check(d, {29'h00000000, 1'b1, tpe_pkg::CTRL_RST});
        xfer(8'h30, 1'b0, 32'h00000000, d);
        check(d, tpe_pkg::UNMAPPED);
        xfer(tpe_pkg::ADR_THRESH, 1'b1, 32'h000003A0, d);
        xfer(tpe_pkg::ADR_THRESH, 1'b0, 32'h00000000, d);
        check(d, 32'h000003A0);
        xfer(tpe_pkg::ADR_THRESH, 1'b1, {20'h00000, tpe_pkg::THRESH_RST}, d);
        xfer(tpe_pkg::ADR_IRQ_CLR, 1'b0, 32'h00000000, d);
        check(d, 32'h00000000);
    endtask : t_regs
    task automatic t_flags;
        logic [31:0] d;
        for (int i = 0; i < 5; i++) begin
            cond <= 5'h01 << i;
            repeat (2) @(posedge sys_clk);
            check({29'h0, f_fatal, f_over, f_under}, {29'h0, cond[4:2]});
            xfer(tpe_pkg::ADR_COND, 1'b0, 32'h00000000, d);
            check(d, {27'h0, cond});
        end
        cond <= 5'h00;
    endtask : t_flags
    task automatic t_relay;
        logic [31:0] d;
        tick_wait;
        check(rel_oe, 1'b1);
        xfer(tpe_pkg::ADR_IRQ_CLR, 1'b1, 32'h00000007, d);
        xfer(tpe_pkg::ADR_IRQ_EN, 1'b1, 32'h00000002, d);
        fine <= 12'h385;
        tick_wait;
        check(rel_oe, 1'b0);
        check(rel_level, 1'b1);
        check(irq, 1'b1);
        // exactly at the release point: hysteresis must hold the state
        fine <= 12'h352;
        tick_wait;
        check(rel_oe, 1'b0);
        fine <= 12'h351;
        tick_wait;
        check(rel_oe, 1'b1);
        xfer(tpe_pkg::ADR_IRQ_EN, 1'b1, 32'h00000000, d);
        check(irq, 1'b0);
        xfer(tpe_pkg::ADR_IRQ_EN, 1'b1, 32'h00000002, d);
        check(irq, 1'b1);
        xfer(tpe_pkg::ADR_IRQ_CLR, 1'b1, 32'h00000002, d);
        xfer(tpe_pkg::ADR_STATUS, 1'b0, 32'h00000000, d);
        check({31'h0, d[1]}, 32'h00000000);
        check(irq, 1'b0);
        xfer(tpe_pkg::ADR_CTRL, 1'b1, 32'h00000003, d);
        check(rel_oe, 1'b0);
        fine <= 12'h385;
        tick_wait;
        check(rel_oe, 1'b1);
        xfer(tpe_pkg::ADR_CTRL, 1'b0, 32'h00000000, d);
        check({31'h0, d[2]}, 32'h00000001);
    endtask : t_relay
    task automatic t_lead;
        check(obj_out, 1'b1);
        check(amb_out, 1'b1);
        check({31'h0, hi_cyc >= 32'h00004E20}, 32'h00000001);
    endtask : t_lead
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_regs;
        t_flags;
        t_relay;
        t_lead;
        wrap_up;
    end
endmodule : testbench
`default_nettype wire

// file: tpe_top.sv
// thermometer pwm encoder with relay comparator and wishbone registers
`timescale 1ns/1ns
`default_nettype none
module tpe_top (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [9:0] obj_temp_in,
    input wire logic [9:0] amb_temp_in,
    input wire logic [11:0] obj_temp_fine,
    input wire logic [4:0] cond_in,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic object_temp_out,
    output logic ambient_temp_out,
    output logic relay_drive_out,
    output logic relay_drive_oe,
    output logic ambient_underflow_flag,
    output logic ambient_overflow_flag,
    output logic memory_fatal_error,
    output logic irq
);
    localparam int NEV = tpe_pkg::NEV;
    logic [12:0] div_cnt;
    logic tick;
    logic [10:0] pos;
    logic [11:0] thresh;
    logic [11:0] hyst;
    logic [1:0] ctrl;
    logic [NEV-1:0] status;
    logic [NEV-1:0] irq_en;
    logic [9:0] obj_val;
    logic [9:0] amb_val;
    tpe_pkg::tpe_mode_t mode;
    tpe_pkg::tpe_mode_t next_mode;
    logic [10:0] obj_end;
    logic [10:0] amb_end;
    logic [10:0] fixed_end;
    logic [9:0] next_obj;
    logic [9:0] next_amb;
    logic frame_start;
    logic wr;
    logic rd;
    logic fault_rise;

    // tick divider: 50 us pwm clock from the system clock
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            div_cnt <= 13'h0000;
        end else if (ce) begin
            if (div_cnt == 13'(tpe_pkg::PWM_TICK_CYC - 1)) begin
                div_cnt <= 13'h0000;
            end else begin
                div_cnt <= div_cnt + 13'h0001;
            end
        end
    end
    assign tick = (div_cnt == 13'(tpe_pkg::PWM_TICK_CYC - 1));

    // frame position wraps naturally at 2048
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pos <= 11'h000;
        end else if (ce && tick) begin
            pos <= 11'(pos + 11'h001);
        end
    end
    assign frame_start = ce && tick && (pos == 11'(tpe_pkg::FRAME_LEN - 1));

    // condition decode, fatal outranks ambient faults
    always_comb begin
        if (cond_in[tpe_pkg::COND_FATAL]) begin
            next_mode = tpe_pkg::TPE_FATAL;
        end else if (cond_in[tpe_pkg::COND_AMB_LO]) begin
            next_mode = tpe_pkg::TPE_UNDER;
        end else if (cond_in[tpe_pkg::COND_AMB_HI]) begin
            next_mode = tpe_pkg::TPE_OVER;
        end else begin
            next_mode = tpe_pkg::TPE_NORMAL;
        end
    end

    // values clamp; ambient fault clamps both channels
    always_comb begin
        next_obj = obj_temp_in;
        next_amb = amb_temp_in;
        if (cond_in[tpe_pkg::COND_OBJ_LO]) begin
            next_obj = tpe_pkg::VAL_MIN;
        end else if (cond_in[tpe_pkg::COND_OBJ_HI]) begin
            next_obj = tpe_pkg::VAL_MAX;
        end
        if (cond_in[tpe_pkg::COND_AMB_LO]) begin
            next_obj = tpe_pkg::VAL_MIN;
            next_amb = tpe_pkg::VAL_MIN;
        end else if (cond_in[tpe_pkg::COND_AMB_HI]) begin
            next_obj = tpe_pkg::VAL_MAX;
            next_amb = tpe_pkg::VAL_MAX;
        end
    end

    // sample once per frame so a frame never carries a torn value
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            mode <= tpe_pkg::TPE_NORMAL;
            obj_val <= tpe_pkg::VAL_MIN;
            amb_val <= tpe_pkg::VAL_MIN;
        end else if (frame_start) begin
            mode <= next_mode;
            obj_val <= next_obj;
            amb_val <= next_amb;
        end
    end

    always_comb begin
        unique case (mode)
            tpe_pkg::TPE_NORMAL: fixed_end = tpe_pkg::LEAD_END;
            tpe_pkg::TPE_UNDER: fixed_end = tpe_pkg::DUTY_UNDER;
            tpe_pkg::TPE_OVER: fixed_end = tpe_pkg::DUTY_OVER;
            tpe_pkg::TPE_FATAL: fixed_end = tpe_pkg::DUTY_FATAL;
        endcase
    end

    // value slot: high from lead end for value ticks, then low
    assign obj_end = (mode == tpe_pkg::TPE_NORMAL) ?
        (tpe_pkg::LEAD_END + {1'b0, obj_val}) : fixed_end;
    assign amb_end = (mode == tpe_pkg::TPE_NORMAL) ?
        (tpe_pkg::LEAD_END + {1'b0, amb_val}) : fixed_end;

    tpe_pwm_ch u_obj (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .ce(ce),
        .tick(tick),
        .pos(pos),
        .high_end(obj_end),
        .pwm(object_temp_out)
    );
    tpe_pwm_ch u_amb (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .ce(ce),
        .tick(tick),
        .pos(pos),
        .high_end(amb_end),
        .pwm(ambient_temp_out)
    );

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ambient_underflow_flag <= 1'b0;
            ambient_overflow_flag <= 1'b0;
            memory_fatal_error <= 1'b0;
        end else if (ce) begin
            ambient_underflow_flag <= cond_in[tpe_pkg::COND_AMB_LO];
            ambient_overflow_flag <= cond_in[tpe_pkg::COND_AMB_HI];
            memory_fatal_error <= cond_in[tpe_pkg::COND_FATAL];
        end
    end

    // relay comparator on object temperature
    tpe_cmp_if c ();
    assign c.temp = obj_temp_fine;
    assign c.thresh = thresh;
    assign c.hyst = hyst;
    assign c.noninv = ctrl[tpe_pkg::CTRL_NONINV];
    assign c.tick = tick;
    tpe_relay_cmp u_cmp (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .ce(ce),
        .c(c)
    );
    // open drain: enable while pulling low, i.e. relay on
    assign relay_drive_out = 1'b0;
    assign relay_drive_oe = ctrl[tpe_pkg::CTRL_ENABLE] & c.drive;

    // wishbone classic slave, one wait-state ack
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && ce;
    assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && ce;
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
        end else if (ce) begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            thresh <= tpe_pkg::THRESH_RST;
            hyst <= tpe_pkg::HYST_RST;
            ctrl <= tpe_pkg::CTRL_RST;
            irq_en <= '0;
        end else if (wr) begin
            if (wb_adr_i == tpe_pkg::ADR_THRESH && wb_sel_i[0] && wb_sel_i[1]) begin
                thresh <= wb_dat_i[11:0];
            end
            if (wb_adr_i == tpe_pkg::ADR_HYST && wb_sel_i[0] && wb_sel_i[1]) begin
                hyst <= wb_dat_i[11:0];
            end
            if (wb_adr_i == tpe_pkg::ADR_CTRL && wb_sel_i[0]) begin
                ctrl <= wb_dat_i[1:0];
            end
            if (wb_adr_i == tpe_pkg::ADR_IRQ_EN && wb_sel_i[0]) begin
                irq_en <= wb_dat_i[NEV-1:0];
            end
        end
    end

    // sticky events; a set in the clear cycle wins
    assign fault_rise = frame_start && (next_mode != tpe_pkg::TPE_NORMAL)
        && (mode == tpe_pkg::TPE_NORMAL);
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            status <= '0;
        end else if (ce) begin
            status <= (status & ~((wr && wb_adr_i == tpe_pkg::ADR_IRQ_CLR && wb_sel_i[0]) ?
                wb_dat_i[NEV-1:0] : {NEV{1'b0}}))
                | {fault_rise, c.change, frame_start};
        end
    end
    assign irq = |(status & irq_en);

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            wb_dat_o <= 32'h00000000;
        end else if (rd) begin
            unique case (wb_adr_i)
                tpe_pkg::ADR_OBJ_TEMP: wb_dat_o <= {22'h000000, obj_val};
                tpe_pkg::ADR_AMB_TEMP: wb_dat_o <= {22'h000000, amb_val};
                tpe_pkg::ADR_COND: wb_dat_o <= {27'h0000000, cond_in};
                tpe_pkg::ADR_CTRL: wb_dat_o <= {29'h00000000, c.drive, ctrl};
                tpe_pkg::ADR_THRESH: wb_dat_o <= {20'h00000, thresh};
                tpe_pkg::ADR_HYST: wb_dat_o <= {20'h00000, hyst};
                tpe_pkg::ADR_STATUS: wb_dat_o <= {29'h00000000, status};
                tpe_pkg::ADR_IRQ_EN: wb_dat_o <= {29'h00000000, irq_en};
                default: wb_dat_o <= tpe_pkg::UNMAPPED;
            endcase
        end
    end
endmodule : tpe_top
`default_nettype wire

// file: tpe_top_checker.sv
// assertions on the ports of the thermometer pwm encoder
`timescale 1ns/1ns
`default_nettype none
module tpe_top_checker (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [4:0] cond_in,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic object_temp_out,
    input wire logic ambient_temp_out,
    input wire logic relay_drive_out,
    input wire logic ambient_underflow_flag,
    input wire logic ambient_overflow_flag,
    input wire logic memory_fatal_error
);
    // the first frame after reset may lose part of one tick, hence 255
    localparam int LEAD_CYC = 255 * 5000;
    // fatal duty plus one tick of alignment slack
    localparam int MAX_HI = 1665 * 5000;
    logic [23:0] obj_hi;
    logic [23:0] amb_hi;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    always_ff @(posedge sys_clk) begin
        obj_hi <= (rst_b && object_temp_out) ? obj_hi + {23'h000000, ce} : 24'h000000;
    end
    always_ff @(posedge sys_clk) begin
        amb_hi <= (rst_b && ambient_temp_out) ? amb_hi + {23'h000000, ce} : 24'h000000;
    end
    sequence s_req;
        wb_cyc_i && wb_stb_i && ce && !wb_ack_o;
    endsequence
    sequence s_ack;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_ack_one_pulse: assert property (s_req |=> s_ack)
        else $error("bus answer missing or too long");
    a_under_flag_copy: assert property (
        ce |=> ambient_underflow_flag == $past(cond_in[2]))
        else $error("underflow flag does not follow its input");
    a_over_flag_copy: assert property (
        ce |=> ambient_overflow_flag == $past(cond_in[3]))
        else $error("overflow flag does not follow its input");
    a_fatal_flag_copy: assert property (
        ce |=> memory_fatal_error == $past(cond_in[4]))
        else $error("fatal flag does not follow its input");
    a_obj_lead_high: assert property (
        $fell(object_temp_out) |-> obj_hi >= LEAD_CYC)
        else $error("object output fell inside the leading interval");
    a_amb_lead_high: assert property (
        $fell(ambient_temp_out) |-> amb_hi >= LEAD_CYC)
        else $error("ambient output fell inside the leading interval");
    a_obj_high_max: assert property (
        object_temp_out |-> obj_hi <= MAX_HI)
        else $error("object output high beyond the longest duty");
    a_relay_pin_low: assert property (relay_drive_out == 1'b0)
        else $error("relay pin driven high");
endmodule : tpe_top_checker
bind tpe_top tpe_top_checker chk (.sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .cond_in(cond_in),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .object_temp_out(object_temp_out), .ambient_temp_out(ambient_temp_out),
    .relay_drive_out(relay_drive_out), .ambient_underflow_flag(ambient_underflow_flag),
    .ambient_overflow_flag(ambient_overflow_flag), .memory_fatal_error(memory_fatal_error));
`default_nettype wire
